// ### design/radbc_ctrl.sv
// Repeat-mode and delayed-branch program-flow controller with APB register access
// Operation
// - Block repeat ends with counter zero; one-instruction block ends all ones.
// - One-instruction block repeat with pipeline conflict ends with counter zero.
// - Single repeat ends all ones; conflict on final cycle ends at zero.
// - Repeated code executes loaded counter value plus one times.
// - Cache enabled: one-instruction block with conflicting read ends all ones.
// - Repeat-mode flag cannot be set while counter is zero or minus one; code checks status writes and pops only, repeat instructions set it regardless.
// - Status pop with counter zero restores all bits but repeat-mode flag.
// - Block end derives next PC from start, end and counter registers.
// - Saving or restoring repeat control registers costs four cycles.
// - Standard branches, repeats included, drain the pipeline: four cycles.
// - Delayed branch runs three following instructions, then redirects.
// - Delayed condition uses flags from the instruction before the branch.
// - Flags update only on extended-register writes, compares and bit tests.
// - Pending delayed branch guarantees the next three instructions execute.
// - Interrupts blocked until three delay slots complete, taken or not.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module radbc_ctrl (
  input wire logic pclk, // APB and core clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [radbc_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire radbc_pkg::radbc_retire_t retire, // Retiring instruction
  output logic redirect, // One-cycle PC redirect
  output logic [31:0] redirect_addr, // Redirect target
  output logic pipe_stall, // Pipeline draining
  output logic irq_allow, // Interrupts may be taken
  output logic fetch_from_ir, // Single repeat: refetch from IR
  output logic repeat_mode // Repeat-mode flag
);
  import radbc_pkg::*;

  radbc_state_t s_q;
  radbc_state_t s_d;

  // Condition test on a flag set
  function automatic logic cond_ok(input radbc_cond_t c, input logic [3:0] f);
    logic r;
    r = 1'b1;
    unique case (c)
      RADBC_C_ALWAYS: r = 1'b1;
      RADBC_C_EQ: r = f[FLAG_Z];
      RADBC_C_NE: r = ~f[FLAG_Z];
      RADBC_C_GE: r = ~f[FLAG_N];
    endcase
    return r;
  endfunction : cond_ok

  // Counter values that forbid repeat mode
  function automatic logic rc_blocks(input logic [31:0] rc);
    return (rc == RC_ZERO) || (rc == RC_ONES);
  endfunction : rc_blocks

  // Address decode helpers
  logic apb_access;
  logic addr_mapped;
  logic addr_repeat;
  logic apb_commit;
  logic [31:0] status_view;
  logic [31:0] read_word;

  assign apb_access = psel & penable;
  assign addr_repeat = (paddr == OFF_RC) || (paddr == OFF_RS) ||
                       (paddr == OFF_RE) || (paddr == OFF_ST);
  assign addr_mapped = addr_repeat || (paddr == OFF_CTRL) || (paddr == OFF_REDIR);
  assign apb_commit = apb_access & s_q.pready & pwrite & addr_mapped;

  // Status word as software sees it
  always_comb begin
    status_view = RC_ZERO;
    status_view[ST_RM] = s_q.rm;
    status_view[ST_S] = s_q.s;
    status_view[ST_IRQ] = irq_allow;
    status_view[ST_SLOT] = (s_q.slot_cnt != CNT_ZERO);
    status_view[ST_FLAG_LSB+:4] = s_q.flags;
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    read_word = RC_ZERO;
    if (paddr == OFF_RC) begin
      read_word = s_q.rc;
    end else if (paddr == OFF_RS) begin
      read_word = s_q.rs;
    end else if (paddr == OFF_RE) begin
      read_word = s_q.re;
    end else if (paddr == OFF_ST) begin
      read_word = status_view;
    end else if (paddr == OFF_CTRL) begin
      read_word[CTRL_CACHE] = s_q.cache_en;
    end else if (paddr == OFF_REDIR) begin
      read_word = s_q.redirect_addr;
    end
  end

  // Next-state logic: core events first, software writes last
  always_comb begin
    s_d = s_q;
    s_d.redirect = 1'b0;

    // Standard branch drain; stalls until the target is issued
    if (s_q.drain_cnt != CNT_ZERO) begin
      s_d.drain_cnt = s_q.drain_cnt - CNT_ONE;
      if (s_q.drain_cnt == CNT_ONE) begin
        s_d.redirect = 1'b1;
        s_d.redirect_addr = s_q.drain_target;
      end
    end

    if (retire.valid) begin
      // Only extended-register writes, compares and bit tests load flags_in
      if (retire.writes_ext || (retire.kind == RADBC_K_FLOAT_COMPARE) ||
          (retire.kind == RADBC_K_INT_COMPARE) || (retire.kind == RADBC_K_BIT_TEST)) begin
        s_d.flags = retire.flags_in;
      end

      // Delay slots run to the end, no flush on conflicts
      if (s_q.slot_cnt != CNT_ZERO) begin
        s_d.slot_cnt = s_q.slot_cnt - CNT_ONE;
        if ((s_q.slot_cnt == CNT_ONE) && s_q.slot_taken) begin
          s_d.redirect = 1'b1;
          s_d.redirect_addr = s_q.slot_target;
        end
      end

      unique case (retire.kind)
        RADBC_K_BLOCK_REPEAT: begin
          s_d.rs = retire.pc + ADDR_STEP;
          s_d.re = retire.operand;
          s_d.rm = 1'b1;
          s_d.s = 1'b0;
          s_d.drain_cnt = STD_DRAIN;
          s_d.drain_target = retire.pc + ADDR_STEP;
        end
        RADBC_K_SINGLE_REPEAT: begin
          s_d.rs = retire.pc + ADDR_STEP;
          s_d.re = retire.pc + ADDR_STEP;
          s_d.rc = retire.operand;
          s_d.rm = 1'b1;
          s_d.s = 1'b1;
          s_d.drain_cnt = STD_DRAIN;
          s_d.drain_target = retire.pc + ADDR_STEP;
        end
        RADBC_K_STD_BRANCH: begin
          s_d.drain_cnt = STD_DRAIN;
          s_d.drain_target = retire.operand;
        end
        RADBC_K_COND_DELAYED, RADBC_K_UNCOND_DELAYED, RADBC_K_DECR_DELAYED: begin
          // Decision frozen now, slot instructions cannot change it
          s_d.slot_cnt = DELAY_SLOTS;
          s_d.slot_target = retire.operand;
          if (retire.kind == RADBC_K_UNCOND_DELAYED) begin
            s_d.slot_taken = 1'b1;
          end else if (retire.kind == RADBC_K_COND_DELAYED) begin
            s_d.slot_taken = cond_ok(retire.cond, s_q.flags);
          end else begin
            s_d.slot_taken = retire.counter_ok & cond_ok(retire.cond, s_q.flags);
          end
        end
        RADBC_K_POP_STATUS: begin
          s_d.flags = retire.operand[ST_FLAG_LSB+:4];
          s_d.rm = retire.operand[ST_RM] & ~rc_blocks(s_q.rc);
          if (!s_d.rm) begin
            s_d.s = 1'b0;
          end
        end
        default: begin
          // End of repeated block: counter and PC come from repeat registers
          if (s_q.rm && (retire.pc == s_q.re)) begin
            if (s_q.rc != RC_ZERO) begin
              s_d.rc = s_q.rc - ADDR_STEP;
              s_d.redirect = 1'b1;
              s_d.redirect_addr = s_q.rs;
            end else begin
              s_d.rm = 1'b0;
              s_d.s = 1'b0;
              if (s_q.s) begin
                s_d.rc = retire.conflict ? RC_ZERO : RC_ONES;
              end else if (s_q.rs != s_q.re) begin
                s_d.rc = RC_ZERO;
              end else if (retire.conflict && !s_q.cache_en) begin
                s_d.rc = RC_ZERO;
              end else begin
                s_d.rc = RC_ONES;
              end
            end
          end
        end
      endcase
    end

    // APB: registered ready, repeat registers wait longer
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (!apb_access || s_q.pready) begin
      s_d.apb_cnt = WAIT_FAST;
    end else if (s_q.apb_cnt == (addr_repeat ? WAIT_REPEAT : WAIT_FAST)) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~addr_mapped;
      s_d.prdata = pwrite ? RC_ZERO : read_word;
    end else begin
      s_d.apb_cnt = s_q.apb_cnt + WAIT_STEP;
    end

    // Software write takes effect at the completing edge
    if (apb_commit) begin
      if (paddr == OFF_RC) begin
        s_d.rc = pwdata;
      end else if (paddr == OFF_RS) begin
        s_d.rs = pwdata;
      end else if (paddr == OFF_RE) begin
        s_d.re = pwdata;
      end else if (paddr == OFF_ST) begin
        // A restored status cannot revive repeat mode on a spent counter
        s_d.flags = pwdata[ST_FLAG_LSB+:4];
        s_d.rm = pwdata[ST_RM] & ~rc_blocks(s_d.rc);
        if (!s_d.rm) begin
          s_d.s = 1'b0;
        end
      end else if (paddr == OFF_CTRL) begin
        s_d.cache_en = pwdata[CTRL_CACHE];
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign redirect = s_q.redirect;
  assign redirect_addr = s_q.redirect_addr;
  assign pipe_stall = (s_q.drain_cnt != CNT_ZERO);
  // Single repeat is never interruptible, the IR word would be lost
  assign irq_allow = (s_q.slot_cnt == CNT_ZERO) && !(s_q.rm && s_q.s);
  assign fetch_from_ir = s_q.rm & s_q.s;
  assign repeat_mode = s_q.rm;
endmodule : radbc_ctrl
`default_nettype wire

// ### design/radbc_pkg.sv
// Constants, field layouts and carrier types for the repeat and delayed-branch controller
package radbc_pkg;
  // APB register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_RC = 8'h00;
  localparam logic [7:0] OFF_RS = 8'h04;
  localparam logic [7:0] OFF_RE = 8'h08;
  localparam logic [7:0] OFF_ST = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_REDIR = 8'h14;
  // Repeat counter end values
  localparam logic [31:0] RC_ZERO = 32'h0000_0000;
  localparam logic [31:0] RC_ONES = 32'hffff_ffff;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0001;
  // Pipeline timing
  localparam logic [1:0] DELAY_SLOTS = 2'h3;
  localparam logic [1:0] STD_DRAIN = 2'h3;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  // APB wait counts: repeat registers cost four cycles
  localparam logic [2:0] WAIT_REPEAT = 3'h3;
  localparam logic [2:0] WAIT_FAST = 3'h0;
  localparam logic [2:0] WAIT_STEP = 3'h1;
  // Status word and control field positions
  localparam int unsigned ST_RM = 0;
  localparam int unsigned ST_S = 1;
  localparam int unsigned ST_IRQ = 2;
  localparam int unsigned ST_SLOT = 3;
  localparam int unsigned ST_FLAG_LSB = 4;
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned CTRL_CACHE = 0;

  typedef enum logic [3:0] {
    RADBC_K_NORMAL = 4'h0,
    RADBC_K_BLOCK_REPEAT = 4'h1,
    RADBC_K_SINGLE_REPEAT = 4'h2,
    RADBC_K_STD_BRANCH = 4'h3,
    RADBC_K_COND_DELAYED = 4'h4,
    RADBC_K_UNCOND_DELAYED = 4'h5,
    RADBC_K_DECR_DELAYED = 4'h6,
    RADBC_K_FLOAT_COMPARE = 4'h7,
    RADBC_K_INT_COMPARE = 4'h8,
    RADBC_K_BIT_TEST = 4'h9,
    RADBC_K_POP_STATUS = 4'ha
  } radbc_kind_t;

  typedef enum logic [1:0] {
    RADBC_C_ALWAYS = 2'h0,
    RADBC_C_EQ = 2'h1,
    RADBC_C_NE = 2'h2,
    RADBC_C_GE = 2'h3
  } radbc_cond_t;

  // One retiring instruction from the core
  typedef struct packed {
    logic valid;
    radbc_kind_t kind;
    radbc_cond_t cond;
    logic [31:0] pc;
    logic [31:0] operand;
    logic writes_ext;
    logic conflict;
    logic counter_ok;
    logic [3:0] flags_in;
  } radbc_retire_t;

  typedef struct packed {
    logic [31:0] rc;
    logic [31:0] rs;
    logic [31:0] re;
    logic rm;
    logic s;
    logic [3:0] flags;
    logic cache_en;
    logic [1:0] slot_cnt;
    logic slot_taken;
    logic [31:0] slot_target;
    logic [1:0] drain_cnt;
    logic [31:0] drain_target;
    logic redirect;
    logic [31:0] redirect_addr;
    logic [2:0] apb_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } radbc_state_t;
endpackage : radbc_pkg

// ### tb/radbc_asserts.sv
// Port checker for the repeat and delayed-branch controller
`timescale 1ns/1ps
`default_nettype none
module radbc_asserts
  import radbc_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic [radbc_pkg::ADDR_W-1:0] paddr, // Address
  input wire logic pready, // Ready
  input wire radbc_pkg::radbc_retire_t retire, // Retiring instruction
  input wire logic redirect, // Redirect pulse
  input wire logic [31:0] redirect_addr, // Redirect target
  input wire logic pipe_stall, // Drain
  input wire logic irq_allow, // Interrupts allowed
  input wire logic fetch_from_ir, // Single repeat active
  input wire logic repeat_mode // Repeat flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic dly;
  // Any of the three delayed branch kinds
  assign dly = retire.valid && retire.kind inside {RADBC_K_COND_DELAYED,
    RADBC_K_UNCOND_DELAYED, RADBC_K_DECR_DELAYED};
  sequence s_drain;
    pipe_stall [*3] ##1 (redirect && !pipe_stall);
  endsequence
  // Only aligned words below the control register are repeat registers
  property p_slow;
    psel && penable && !$past(penable) && paddr <= OFF_ST && paddr[1:0] == 2'h0 |->
      !pready [*4] ##1 pready;
  endproperty
  property p_fast;
    psel && penable && !$past(penable) && paddr >= OFF_CTRL |-> !pready ##1 pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_std;
    retire.valid && retire.kind == RADBC_K_STD_BRANCH |=>
      s_drain ##0 (redirect_addr == $past(retire.operand, 4)) ##1 !redirect;
  endproperty
  property p_slot;
    dly |=> !irq_allow && !redirect && !pipe_stall;
  endproperty
  // Without a retire the pending slots cannot complete
  property p_hold;
    !irq_allow && !fetch_from_ir && !retire.valid |=> !irq_allow;
  endproperty
  property p_rise;
    $rose(irq_allow) && !$past(fetch_from_ir) |-> $past(retire.valid);
  endproperty
  // Refetch from IR only ever starts from a single-repeat instruction
  property p_ir;
    $rose(fetch_from_ir) |-> $past(retire.valid && retire.kind == RADBC_K_SINGLE_REPEAT);
  endproperty
  a_slow: assert property (p_slow) else $error("slow register answer late");
  a_fast: assert property (p_fast) else $error("fast register answer late");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_std: assert property (p_std) else $error("standard branch timing");
  a_slot: assert property (p_slot) else $error("delayed branch not pending");
  a_hold: assert property (p_hold) else $error("slots ended early");
  a_rise: assert property (p_rise) else $error("interrupts reopened idle");
  a_ir: assert property (p_ir) else $error("single repeat state wrong");
endmodule : radbc_asserts
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the repeat and delayed-branch controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import radbc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, redirect_addr, q;
  logic pready, pslverr, redirect, pipe_stall, irq_allow, fetch_from_ir, repeat_mode, e, seen, tk;
  radbc_retire_t retire = '0;
  radbc_retire_t r;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'hff427232;
  int n, k, reps;
  always #50 pclk = ~pclk;
  radbc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .retire(retire), .redirect(redirect), .redirect_addr(redirect_addr),
    .pipe_stall(pipe_stall), .irq_allow(irq_allow), .fetch_from_ir(fetch_from_ir),
    .repeat_mode(repeat_mode));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; only the watchdog ends a hung wait for ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Valid stays up so back-to-back retires need no gap
  task rt(input radbc_kind_t kd, input logic [31:0] pc);
    r.valid = 1'b1;
    r.kind = kd;
    r.pc = pc;
    retire <= r;
    @(posedge pclk);
  endtask : rt
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_ST, 32'h0);
    chk(q, 32'h4);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0);
    chk(k, 2);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFF_RC, i ? RC_ZERO : RC_ONES);
      chk(k, 5);
      apb(1'b1, OFF_ST, 32'h1);
      chk({31'h0, repeat_mode}, 32'h0);
    end
    // Status pop with counter at zero keeps repeat mode off
    r = '0;
    r.operand = 32'hf1;
    rt(RADBC_K_POP_STATUS, 32'h10);
    r.flags_in = 4'h3;
    rt(RADBC_K_NORMAL, 32'h11);
    retire.valid <= 1'b0;
    @(posedge pclk);
    apb(1'b0, OFF_ST, 32'h0);
    chk(q & 32'hf1, 32'hf0);
    r.writes_ext = 1'b1;
    rt(RADBC_K_NORMAL, 32'h12);
    retire.valid <= 1'b0;
    @(posedge pclk);
    apb(1'b0, OFF_ST, 32'h0);
    chk(q & 32'hf0, 32'h30);
    // Delayed branches of every kind, flags from a random compare or bit test
    for (int i = 0; i < 6; i++) begin
      r = '0;
      r.flags_in = 4'($random(seed));
      r.cond = radbc_cond_t'(2'(i > 3 ? 0 : i));
      case (i)
        1: tk = r.flags_in[FLAG_Z];
        2: tk = !r.flags_in[FLAG_Z];
        3: tk = !r.flags_in[FLAG_N];
        default: tk = 1'b1;
      endcase
      rt(i < 2 ? RADBC_K_BIT_TEST : i < 4 ? RADBC_K_INT_COMPARE : RADBC_K_FLOAT_COMPARE, 32'h40);
      r.operand = 32'h100 + i;
      r.counter_ok = 1'b1;
      rt(i < 4 ? RADBC_K_COND_DELAYED : i == 4 ? RADBC_K_UNCOND_DELAYED : RADBC_K_DECR_DELAYED,
        32'h41);
      r.flags_in = ~r.flags_in;
      r.writes_ext = 1'b1;
      rt(RADBC_K_FLOAT_COMPARE, 32'h42);
      rt(RADBC_K_NORMAL, 32'h43);
      rt(RADBC_K_NORMAL, 32'h44);
      retire.valid <= 1'b0;
      #1;
      chk({31'h0, redirect}, {31'h0, tk});
      chk({31'h0, irq_allow}, 32'h1);
      if (tk) chk(redirect_addr, 32'h100 + i);
      @(posedge pclk);
    end
    r = '0;
    r.operand = $random(seed);
    rt(RADBC_K_STD_BRANCH, 32'h50);
    retire.valid <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (redirect !== 1'b1 && k < 9);
    chk(k, 4);
    chk(redirect_addr, r.operand);
    apb(1'b0, OFF_REDIR, 32'h0);
    chk(q, r.operand);
    // Repeats: long block, size one by instruction, conflict, conflict with cache, single
    for (int c = 0; c < 6; c++) begin
      n = 1 + $unsigned($random(seed)) % 3;
      r = '0;
      r.conflict = (c == 2) || (c == 3) || (c == 5);
      apb(1'b1, OFF_CTRL, {31'h0, c == 3});
      if (c == 0 || c == 2 || c == 3) begin
        // Counter, end, start, then status: addresses stand before the mode bit
        apb(1'b1, OFF_RC, n);
        apb(1'b1, OFF_RE, c ? 32'h20 : 32'h22);
        apb(1'b1, OFF_RS, 32'h20);
        apb(1'b1, OFF_ST, 32'h1);
      end else begin
        if (c == 1) apb(1'b1, OFF_RC, n);
        r.operand = c == 1 ? 32'h20 : n;
        rt(c == 1 ? RADBC_K_BLOCK_REPEAT : RADBC_K_SINGLE_REPEAT, 32'h1f);
        retire.valid <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({29'h0, fetch_from_ir, irq_allow, redirect}, {29'h0, c > 3, c < 4, 1'b1});
        chk(redirect_addr, 32'h20);
      end
      reps = 0;
      seen = 1'b1;
      while (seen && reps < 9) begin
        reps++;
        for (int p = 32'h20; p <= (c ? 32'h20 : 32'h22); p++) rt(RADBC_K_NORMAL, p);
        retire.valid <= 1'b0;
        @(posedge pclk);
        seen = redirect;
        @(posedge pclk);
        seen |= redirect;
        if (seen) chk(redirect_addr, 32'h20);
      end
      chk(reps, n + 1);
      apb(1'b0, OFF_RC, 32'h0);
      chk(q, (c == 1 || c == 3 || c == 4) ? RC_ONES : RC_ZERO);
      chk({30'h0, repeat_mode, fetch_from_ir}, 32'h0);
    end
    conclude();
  end
endmodule : testbench
bind radbc_ctrl radbc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .retire(retire), .redirect(redirect),
  .redirect_addr(redirect_addr), .pipe_stall(pipe_stall), .irq_allow(irq_allow),
  .fetch_from_ir(fetch_from_ir), .repeat_mode(repeat_mode));
`default_nettype wire
